// file: ctf_regs.svh
// Register offsets, field positions, reset values and character codes of the tolerance FIFO.
`ifndef CTF_REGS_SVH
`define CTF_REGS_SVH
`define CTF_OFF_CTRL 8'h00
`define CTF_OFF_DEPTH 8'h04
`define CTF_OFF_LOW 8'h08
`define CTF_OFF_HIGH 8'h0C
`define CTF_OFF_FILL 8'h10
`define CTF_OFF_STAT 8'h14
`define CTF_OFF_MASK 8'h18
`define CTF_OFF_COLL 8'h1C
`define CTF_CTRL_EN 0
`define CTF_CTRL_1G 1
`define CTF_RST_CTRL 2'h1
`define CTF_RST_DEPTH 5'h0C
`define CTF_RST_LOW 5'h04
`define CTF_RST_HIGH 5'h08
`define CTF_MIN_DEPTH 5'h02
`define CTF_1G_DEPTH 5'h0C
`define CTF_1G_LOW 5'h02
`define CTF_1G_HIGH 5'h06
`define CTF_ST_INS 0
`define CTF_ST_DEL 1
`define CTF_ST_COLL 2
`define CTF_ST_W 3
`define CTF_CH_IDLE 8'h07
`define CTF_CH_ALIGN 8'h7C
`define CTF_CH_COMMA 8'hBC
`define CTF_CH_REPL 8'h1C
`define CTF_CH_ERR 8'hFE
`endif

// file: ctf_pkg.sv
// Types shared by the clock tolerance FIFO.
package ctf_pkg;
  // One four-lane column: a control flag and a byte per lane.
  typedef struct packed {
    logic [3:0] ctl;
    logic [31:0] data;
  } ctf_col_t;
  // Progress of a two-cycle insertion or deletion.
  typedef enum logic {CTF_ADJ_OFF, CTF_ADJ_SECOND} ctf_adj_t;
endpackage

// file: ctf_top.sv
// Clock tolerance compensation FIFO with an AHB-Lite register slave.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "ctf_regs.svh"
// Summary of operation
// [RL1] Insert or drop idle columns across all lanes.
// [RL2] Keep the FIFO from overrunning or underrunning.
// [RL3] Depth and thresholds are software provisionable.
// [RL4] 1G mode adjusts two cycles in clean gaps.
// [RL5] 1G mode tolerates 200 ppm clock offset.
// [RL6] 1G FIFO has twelve entries, eight working; the code works all twelve, wrapping the pointers at twelve.
// [RL7] Fill count and pointer compare kept separately.
// [RL8] Pointer collision resets the FIFO automatically.
// [RL9] Collision flag stays set until read.
// [RL10] Sender supplies idles between packets.
// [RL11] Alignment, comma, replacement become idle first.
// [RL12] Insert below low, delete above high threshold.
module ctf_top
  import ctf_pkg::*;
#(
  parameter int DEPTH_MAX = 16
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Write side column stream.
  input wire logic in_valid,
  input wire ctf_col_t in_data,
  output logic in_ready,
  // Read side column stream.
  input wire logic out_ready,
  output logic out_valid,
  output ctf_col_t out_data,
  // Interrupt.
  output logic irq
);
  localparam int AW = $clog2(DEPTH_MAX);
  localparam ctf_col_t IDLE_COL = '{ctl: 4'hF, data: {4{`CTF_CH_IDLE}}};

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Turns alignment, comma and replacement characters into idles.
  function automatic ctf_col_t to_idle(input ctf_col_t c);
    ctf_col_t r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      if (c.ctl[i] && (c.data[8*i+:8] == `CTF_CH_ALIGN || c.data[8*i+:8] == `CTF_CH_COMMA ||
          c.data[8*i+:8] == `CTF_CH_REPL)) begin
        r.data[8*i+:8] = `CTF_CH_IDLE; // RL11
      end
    end
    return r;
  endfunction

  // True when every lane of the column carries an idle.
  function automatic logic is_idle(input ctf_col_t c);
    return (c.ctl == 4'hF) && (c.data == {4{`CTF_CH_IDLE}});
  endfunction

  // Advances a pointer, wrapping at the working depth and flipping its lap bit.
  function automatic logic [AW:0] ptr_inc(input logic [AW:0] p, input logic [4:0] depth);
    logic [AW:0] r;
    r = p;
    if ({{(5 - AW){1'b0}}, p[AW-1:0]} == depth - 5'h01) begin
      r = {~p[AW], {AW{1'b0}}};
    end else begin
      r[AW-1:0] = p[AW-1:0] + 1'b1;
    end
    return r;
  endfunction

  // Clamps a provisioned figure into the legal range.
  function automatic logic [4:0] clamp(input logic [4:0] v, input logic [4:0] lo, input logic [4:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ************************************************************
  // Register state
  // ************************************************************

  logic [1:0] ctrl_q;
  logic [4:0] depth_q, low_q, high_q;
  logic [`CTF_ST_W-1:0] stat_q, mask_q;
  logic coll_flag_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic ap_go, ap_read_coll, cfg_chg;

  // ************************************************************
  // FIFO state
  // ************************************************************

  ctf_col_t mem [DEPTH_MAX];
  logic [AW:0] wp_q, rp_q;
  logic [4:0] fill_q;
  logic primed_q, last_in_idle_q, last_out_idle_q, gap_err_q;
  ctf_adj_t wadj_q, radj_q;
  ctf_col_t out_q, in_col, head;
  logic en, mode_1g, gap_clean, empty, full;
  logic [4:0] eff_depth, low_th, high_th;
  logic wr_go, rd_go, del_start, del_second, drop, wr_push;
  logic ins_start, ins_second, ins, rd_pop, overrun, underrun, coll, flush;

  // Working figures: the 1G variant is fixed at twelve working entries with thresholds at two and six.
  assign en = ctrl_q[`CTF_CTRL_EN];
  assign mode_1g = ctrl_q[`CTF_CTRL_1G];
  assign eff_depth = mode_1g ? `CTF_1G_DEPTH : clamp(depth_q, `CTF_MIN_DEPTH, 5'(DEPTH_MAX)); // RL3 RL6
  assign low_th = mode_1g ? `CTF_1G_LOW : low_q; // RL3 RL6
  assign high_th = mode_1g ? `CTF_1G_HIGH : high_q; // RL3 RL6

  // Write side: convert, then decide whether this idle column is dropped.
  assign in_col = to_idle(in_data); // RL11
  assign wr_go = in_valid && en;
  assign gap_clean = !mode_1g || !gap_err_q; // RL4
  assign del_start = wr_go && is_idle(in_col) && last_in_idle_q && gap_clean &&
                     (fill_q > high_th) && (wadj_q == CTF_ADJ_OFF); // RL1 RL12
  assign del_second = wr_go && is_idle(in_col) && (wadj_q == CTF_ADJ_SECOND); // RL4
  assign drop = del_start || del_second;
  assign wr_push = wr_go && !drop;

  // Read side: reading starts once the FIFO has primed up to the low threshold.
  assign head = mem[rp_q[AW-1:0]];
  assign rd_go = out_ready && en && primed_q;
  assign ins_start = rd_go && !empty && is_idle(head) && last_out_idle_q && gap_clean &&
                     (fill_q < low_th) && (radj_q == CTF_ADJ_OFF); // RL1 RL12
  assign ins_second = rd_go && (radj_q == CTF_ADJ_SECOND); // RL4
  assign ins = ins_start || ins_second;
  assign rd_pop = rd_go && !ins && !empty;

  // Collision is judged from the raw pointers, apart from the fill count that steers adjustment.
  assign empty = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] == rp_q[AW]); // RL7
  assign full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]); // RL7
  assign overrun = wr_push && full && !rd_pop;
  assign underrun = rd_go && !ins && empty;
  assign coll = overrun || underrun;
  assign flush = coll || !en || cfg_chg; // RL8

  // Pointers restart together after a collision so the stream resumes without software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (flush) begin
      wp_q <= '0; // RL8
      rp_q <= '0; // RL8
    end else begin
      if (wr_push) begin
        wp_q <= ptr_inc(wp_q, eff_depth); // RL2
      end
      if (rd_pop) begin
        rp_q <= ptr_inc(rp_q, eff_depth); // RL2
      end
    end
  end

  // Fill count drives the threshold decisions and the FILL register, not collision.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_q <= '0;
      primed_q <= 1'b0;
    end else if (flush) begin
      fill_q <= '0; // RL7
      primed_q <= 1'b0;
    end else begin
      fill_q <= fill_q + {4'h0, wr_push} - {4'h0, rd_pop}; // RL7
      if (fill_q >= low_th) begin
        primed_q <= 1'b1;
      end
    end
  end

  // Storage has no reset; its contents mean nothing until the pointers move.
  always_ff @(posedge hclk) begin
    if (wr_push && !full) begin
      mem[wp_q[AW-1:0]] <= in_col;
    end
  end

  // Gap tracking: an error character spoils the gap until the next packet starts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_err_q <= 1'b0;
      last_in_idle_q <= 1'b0;
    end else if (wr_go) begin
      last_in_idle_q <= is_idle(in_col);
      if (|(in_col.ctl & {in_col.data[31:24] == `CTF_CH_ERR, in_col.data[23:16] == `CTF_CH_ERR,
                          in_col.data[15:8] == `CTF_CH_ERR, in_col.data[7:0] == `CTF_CH_ERR})) begin
        gap_err_q <= 1'b1; // RL4
      end else if (!is_idle(in_col)) begin
        gap_err_q <= 1'b0;
      end
    end
  end

  // Two-cycle sequencing of deletions in the 1G variant.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wadj_q <= CTF_ADJ_OFF;
    end else if (wr_go || flush) begin
      unique case (wadj_q)
        CTF_ADJ_OFF: wadj_q <= (del_start && mode_1g && !flush) ? CTF_ADJ_SECOND : CTF_ADJ_OFF; // RL4 RL5
        CTF_ADJ_SECOND: wadj_q <= CTF_ADJ_OFF;
      endcase
    end
  end

  // Two-cycle sequencing of insertions in the 1G variant.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      radj_q <= CTF_ADJ_OFF;
    end else if (rd_go || flush) begin
      unique case (radj_q)
        CTF_ADJ_OFF: radj_q <= (ins_start && mode_1g && !flush) ? CTF_ADJ_SECOND : CTF_ADJ_OFF; // RL4 RL5
        CTF_ADJ_SECOND: radj_q <= CTF_ADJ_OFF;
      endcase
    end
  end

  // Output column: an inserted or starved slot carries a whole idle column.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= IDLE_COL;
      out_valid <= 1'b0;
      last_out_idle_q <= 1'b0;
    end else begin
      out_valid <= rd_go;
      if (rd_go) begin
        out_q <= rd_pop ? head : IDLE_COL; // RL1
        last_out_idle_q <= rd_pop ? is_idle(head) : 1'b1;
      end
    end
  end

  assign out_data = out_q;
  assign in_ready = en;

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************

  // Zero wait states; read data is captured in the address phase.
  assign ap_go = hsel && htrans[1] && hready;
  assign ap_read_coll = ap_go && !hwrite && (haddr[7:0] == `CTF_OFF_COLL);
  assign cfg_chg = wr_pend_q && (wr_addr_q == `CTF_OFF_CTRL || wr_addr_q == `CTF_OFF_DEPTH);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Address phase capture and read mux; unmapped reads return zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= '0;
    end else begin
      wr_pend_q <= ap_go && hwrite;
      if (ap_go) begin
        wr_addr_q <= haddr[7:0];
      end
      if (ap_go && !hwrite) begin
        unique case (haddr[7:0])
          `CTF_OFF_CTRL: hrdata_q <= {30'h0, ctrl_q};
          `CTF_OFF_DEPTH: hrdata_q <= {27'h0, depth_q};
          `CTF_OFF_LOW: hrdata_q <= {27'h0, low_q};
          `CTF_OFF_HIGH: hrdata_q <= {27'h0, high_q};
          `CTF_OFF_FILL: hrdata_q <= {27'h0, fill_q};
          `CTF_OFF_STAT: hrdata_q <= {29'h0, stat_q};
          `CTF_OFF_MASK: hrdata_q <= {29'h0, mask_q};
          `CTF_OFF_COLL: hrdata_q <= {31'h0, coll_flag_q};
          default: hrdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration writes land in the data phase; a mode or depth change flushes the FIFO.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `CTF_RST_CTRL;
      depth_q <= `CTF_RST_DEPTH;
      low_q <= `CTF_RST_LOW;
      high_q <= `CTF_RST_HIGH;
      mask_q <= '0;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `CTF_OFF_CTRL) ctrl_q <= hwdata[1:0];
      if (wr_addr_q == `CTF_OFF_DEPTH) depth_q <= hwdata[4:0]; // RL3
      if (wr_addr_q == `CTF_OFF_LOW) low_q <= hwdata[4:0]; // RL3
      if (wr_addr_q == `CTF_OFF_HIGH) high_q <= hwdata[4:0]; // RL3
      if (wr_addr_q == `CTF_OFF_MASK) mask_q <= hwdata[`CTF_ST_W-1:0];
    end
  end

  // Sticky events, write one to clear; a new event in the clearing cycle survives.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr_pend_q && wr_addr_q == `CTF_OFF_STAT) ? hwdata[`CTF_ST_W-1:0] : '0)) |
                {coll, del_start, ins_start};
    end
  end

  // Collision flag clears when read; a collision in the reading cycle wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coll_flag_q <= 1'b0;
    end else begin
      coll_flag_q <= coll || (coll_flag_q && !ap_read_coll); // RL9
    end
  end

  assign irq = |(stat_q & mask_q);

  // ************************************************************
  // Assertions
  // ************************************************************

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_coll_latch;
    coll |=> coll_flag_q ##1 (coll_flag_q || $past(ap_read_coll));
  endproperty
  a_coll_latch: assert property (p_coll_latch) else $error("collision flag not latched"); // RL9

  property p_flag_holds;
    coll_flag_q && !ap_read_coll |=> coll_flag_q;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("collision flag dropped unread"); // RL9

  property p_auto_reset;
    coll |=> (fill_q == 5'h00) && (wp_q == rp_q);
  endproperty
  a_auto_reset: assert property (p_auto_reset) else $error("FIFO not reset after collision"); // RL8

  property p_ins_level;
    ins_start |-> (fill_q < low_th) && is_idle(head) ##1 out_valid && is_idle(out_q);
  endproperty
  a_ins_level: assert property (p_ins_level) else $error("insertion without low fill"); // RL12

  property p_del_level;
    del_start |-> (fill_q > high_th) && is_idle(in_col) && !wr_push;
  endproperty
  a_del_level: assert property (p_del_level) else $error("deletion without high fill"); // RL12

  property p_ins_two;
    ins_start && mode_1g && !flush |=> (radj_q == CTF_ADJ_SECOND) && (!rd_go || ins);
  endproperty
  a_ins_two: assert property (p_ins_two) else $error("1G insertion not two cycles"); // RL4

  property p_clean_gap;
    (ins_start || del_start) && mode_1g |-> !gap_err_q;
  endproperty
  a_clean_gap: assert property (p_clean_gap) else $error("adjustment in errored gap"); // RL4

  property p_no_akr;
    out_valid |-> !(out_q.ctl[0] && (out_q.data[7:0] == `CTF_CH_ALIGN || out_q.data[7:0] == `CTF_CH_COMMA ||
                    out_q.data[7:0] == `CTF_CH_REPL));
  endproperty
  a_no_akr: assert property (p_no_akr) else $error("alignment character left in stream"); // RL11

  property p_fill_bound;
    fill_q <= eff_depth;
  endproperty
  a_fill_bound: assert property (p_fill_bound) else $error("fill beyond working depth"); // RL2 RL6

  property p_irq;
    irq == |(stat_q & mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt disagrees with status");
endmodule

// file: ctf_partner.sv
// Behavioural far side of the tolerance FIFO: an idle-filling sender and a paced reader.
`timescale 1ns/100ps
module ctf_partner
  import ctf_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bench controls; rate 0 stops, 1 every cycle, 2 every other, 3 every fourth.
  input wire logic pkt_valid,
  input wire ctf_col_t pkt_col,
  input wire logic [1:0] wr_rate,
  input wire logic [1:0] rd_rate,
  // Stream pins of the block.
  output logic in_valid,
  output ctf_col_t in_data,
  output logic out_ready
);
  logic [1:0] cnt_q;
  logic wr_slot;
  // ****************************************
  // Pacing
  // ****************************************
  // Free running phase counter shared by both rates, so they stay unrelated to the data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // A slot falls where the counter bits under the rate mask are zero.
  always_comb begin
    wr_slot = (wr_rate != 2'h0) && ((cnt_q & {wr_rate == 2'h3, wr_rate[1]}) == 2'h0);
    out_ready = (rd_rate != 2'h0) && ((cnt_q & {rd_rate == 2'h3, rd_rate[1]}) == 2'h0);
  end
  // Gaps carry idle columns; an unused bus shows the inverse of the last column, never a stale copy.
  always_comb begin
    in_valid = pkt_valid | wr_slot;
    if (pkt_valid) begin
      in_data = pkt_col;
    end else if (wr_slot) begin
      in_data = {4'hF, 32'h07070707};
    end else begin
      in_data = ~pkt_col;
    end
  end
endmodule

// file: test_clock_tolerance_fifo.sv
// Self-checking testbench of the clock tolerance FIFO.
`timescale 1ns/100ps
`include "ctf_regs.svh"
module test_clock_tolerance_fifo
  import ctf_pkg::*;
;
  localparam ctf_col_t IDLE_COL = {4'hF, 32'h07070707};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, irq, in_valid, in_ready, out_ready, out_valid;
  logic [31:0] hrdata, rd;
  ctf_col_t in_data, out_data;
  ctf_col_t pkt_col = '0;
  logic pkt_valid = 1'b0;
  logic [1:0] wr_rate = 2'h0;
  logic [1:0] rd_rate = 2'h0;
  logic track = 1'b1;
  ctf_col_t exp_q[$];
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h72d6;
  // ****************************************
  // Structure
  // ****************************************
  // The one slave's ready is the bus ready.
  ctf_top #(.DEPTH_MAX(16)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data), .irq(irq));
  ctf_partner u_far (.hclk(hclk), .hresetn(hresetn), .pkt_valid(pkt_valid), .pkt_col(pkt_col),
    .wr_rate(wr_rate), .rd_rate(rd_rate), .in_valid(in_valid), .in_data(in_data), .out_ready(out_ready));
  // Clock of 20 ns.
  always #10 hclk = ~hclk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_col(input ctf_col_t got, input ctf_col_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t column %h expected %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; the watchdog bounds both waits for ready.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk32(rd & m, exp);
  endtask
  // The interrupt is looked at mid-cycle, after register updates have landed.
  task automatic ichk(input logic exp);
    @(negedge hclk);
    chk32({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic send(input ctf_col_t c, input ctf_col_t e);
    @(posedge hclk);
    pkt_valid <= 1'b1;
    pkt_col <= c;
    exp_q.push_back(e);
  endtask
  task automatic burst(input int n);
    ctf_col_t c;
    repeat (n) begin
      c = {4'h0, $random(seed)};
      send(c, c);
    end
    @(posedge hclk);
    pkt_valid <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // ****************************************
  // Checking
  // ****************************************
  // Every data column leaving the block while track is set is matched against the oldest note; idles are free to come and go.
  always @(negedge hclk) begin
    if (track && out_valid === 1'b1 && out_data !== IDLE_COL) begin
      if (exp_q.size() == 0) begin
        chk_col(out_data, IDLE_COL);
      end else begin
        chk_col(out_data, exp_q.pop_front());
      end
    end
  end
  // The sequence needs about 530 cycles; the 15000-cycle limit, some twenty-eight times that, means a hang.
  initial begin
    #300000;
    errors++;
    stop_test();
  end
  // ****************************************
  // Sequence
  // ****************************************
  // Reset for two cycles, then registers, stream, events, collision and the gigabit mode.
  initial begin
    idle(2);
    hresetn <= 1'b1;
    rchk(`CTF_OFF_CTRL, 32'hFFFFFFFF, {30'h0, `CTF_RST_CTRL});
    rchk(`CTF_OFF_DEPTH, 32'hFFFFFFFF, {27'h0, `CTF_RST_DEPTH});
    rchk(`CTF_OFF_LOW, 32'hFFFFFFFF, {27'h0, `CTF_RST_LOW});
    rchk(`CTF_OFF_HIGH, 32'hFFFFFFFF, {27'h0, `CTF_RST_HIGH});
    rchk(`CTF_OFF_FILL, 32'hFFFFFFFF, 32'h0);
    rchk(`CTF_OFF_MASK, 32'hFFFFFFFF, 32'h0);
    rchk(`CTF_OFF_COLL, 32'hFFFFFFFF, 32'h0);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    ahb(1'b1, `CTF_OFF_DEPTH, 32'h1F);
    rchk(`CTF_OFF_DEPTH, 32'h1F, 32'h1F);
    ahb(1'b1, `CTF_OFF_DEPTH, 32'h0);
    rchk(`CTF_OFF_DEPTH, 32'h1F, 32'h0);
    ahb(1'b1, `CTF_OFF_DEPTH, 32'h0C);
    ahb(1'b1, `CTF_OFF_HIGH, 32'h09);
    rchk(`CTF_OFF_HIGH, 32'h1F, 32'h09);
    ahb(1'b1, `CTF_OFF_HIGH, 32'h08);
    wr_rate <= 2'h1;
    rd_rate <= 2'h1;
    idle(10);
    burst(20);
    send({4'hE, 32'h1CBC7C5A}, {4'hE, 32'h0707075A});
    @(posedge hclk);
    pkt_valid <= 1'b0;
    idle(60);
    chk32(exp_q.size(), 32'h0);
    rd_rate <= 2'h2;
    idle(60);
    wr_rate <= 2'h0;
    rd_rate <= 2'h0;
    rchk(`CTF_OFF_STAT, 32'h2, 32'h2);
    ichk(1'b0);
    ahb(1'b1, `CTF_OFF_MASK, 32'h2);
    ichk(1'b1);
    ahb(1'b1, `CTF_OFF_STAT, 32'h7);
    rchk(`CTF_OFF_STAT, 32'h7, 32'h0);
    ichk(1'b0);
    wr_rate <= 2'h3;
    rd_rate <= 2'h1;
    idle(60);
    rchk(`CTF_OFF_STAT, 32'h1, 32'h1);
    ichk(1'b0);
    wr_rate <= 2'h0;
    rd_rate <= 2'h0;
    track <= 1'b0;
    ahb(1'b1, `CTF_OFF_STAT, 32'h7);
    burst(16);
    idle(4);
    exp_q.delete();
    rchk(`CTF_OFF_COLL, 32'h1, 32'h1);
    rchk(`CTF_OFF_COLL, 32'h1, 32'h0);
    rchk(`CTF_OFF_STAT, 32'h4, 32'h4);
    // Columns written after the collision are flushed so the next burst starts clean.
    ahb(1'b1, `CTF_OFF_CTRL, 32'h1);
    track <= 1'b1;
    wr_rate <= 2'h1;
    rd_rate <= 2'h1;
    burst(10);
    idle(60);
    chk32(exp_q.size(), 32'h0);
    ahb(1'b1, `CTF_OFF_CTRL, 32'h3);
    ahb(1'b1, `CTF_OFF_STAT, 32'h7);
    rd_rate <= 2'h2;
    idle(60);
    rchk(`CTF_OFF_STAT, 32'h2, 32'h2);
    rd_rate <= 2'h1;
    burst(12);
    idle(60);
    chk32(exp_q.size(), 32'h0);
    stop_test();
  end
endmodule
